// ==== src/i2c_reg_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module i2c_reg_master #(
    parameter int unsigned QUARTER_CYC = i2c_link_pkg::QUARTER_CYC
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    i2c_link_if.master link,
    input wire logic cmd_valid_i,
    input wire logic cmd_read_i,
    input wire logic cmd_last_i,
    input wire logic [7:0] cmd_index_i,
    input wire logic [7:0] cmd_data_i,
    output logic cmd_ready_o,
    output logic done_o,
    output logic nack_o,
    output logic [7:0] rd_data_o,
    output logic busy_o
);
    import i2c_link_pkg::*;

    localparam int unsigned QW = (QUARTER_CYC > 1) ? $clog2(QUARTER_CYC) : 1;

    logic scl_s;
    logic sda_s;
    logic tick;
    logic [8:0] rx_full;
    logic ack_ok;

    master_state_t state_q, state_d;
    master_step_t step_q, step_d;
    logic [QW-1:0] qcnt_q, qcnt_d;
    logic [1:0] quarter_q, quarter_d;
    logic [3:0] bit_q, bit_d;
    logic [8:0] tx_q, tx_d;
    logic [8:0] rx_q, rx_d;
    logic scl_oe_q, scl_oe_d;
    logic sda_oe_q, sda_oe_d;
    logic read_q, read_d;
    logic last_q, last_d;
    logic [7:0] data_q, data_d;
    logic [7:0] index_q, index_d;
    logic ready_d, done_d, nack_d, busy_d;
    logic [7:0] rd_data_d;

    pin_sync #(
        .WIDTH(2)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .d_i({link.scl, link.sda}),
        .q_o({scl_s, sda_s})
    );

    // Quarter-bit tick sets the bit rate to at most the ceiling
    assign tick = (qcnt_q == QW'(QUARTER_CYC - 1));
    assign rx_full = {rx_q[7:0], sda_s};
    assign ack_ok = (rx_full[0] == ACK_LEVEL);

    assign link.scl_m_o = 1'b0;
    assign link.scl_m_oe = scl_oe_q;
    assign link.sda_m_o = 1'b0;
    assign link.sda_m_oe = sda_oe_q;

    // Sequencer: every step lasts four quarters; data bits move with clock low, start and stop move data with clock high
    always_comb begin
        state_d = state_q;
        step_d = step_q;
        qcnt_d = (state_q == M_IDLE || state_q == M_HOLD || tick) ? '0 : qcnt_q + QW'(1);
        quarter_d = quarter_q;
        bit_d = bit_q;
        tx_d = tx_q;
        rx_d = rx_q;
        scl_oe_d = scl_oe_q;
        sda_oe_d = sda_oe_q;
        read_d = read_q;
        last_d = last_q;
        data_d = data_q;
        index_d = index_q;
        done_d = 1'b0;
        nack_d = nack_o;
        busy_d = busy_o;
        rd_data_d = rd_data_o;
        case (state_q)
            M_IDLE, M_HOLD: begin
                if (cmd_valid_i) begin
                    read_d = cmd_read_i;
                    last_d = cmd_last_i;
                    index_d = cmd_index_i;
                    data_d = cmd_data_i;
                    nack_d = 1'b0;
                    busy_d = 1'b1;
                    quarter_d = 2'd0;
                    bit_d = 4'h0;
                    rx_d = 9'h000;
                    scl_oe_d = 1'b1;
                    if (state_q == M_HOLD && !cmd_read_i) begin
                        // Further pair without resending the address
                        state_d = M_BYTE;
                        step_d = S_INDEX;
                        tx_d = {cmd_index_i, 1'b1};
                    end else begin
                        state_d = M_START;
                        step_d = S_ADDR_W;
                    end
                end
            end
            M_START: begin
                if (tick) begin
                    quarter_d = quarter_q + 2'd1;
                    case (quarter_q)
                        2'd0: sda_oe_d = 1'b0;
                        2'd1: scl_oe_d = 1'b0;
                        2'd2: sda_oe_d = 1'b1;
                        default: begin
                            scl_oe_d = 1'b1;
                            state_d = M_BYTE;
                            bit_d = 4'h0;
                            rx_d = 9'h000;
                            tx_d = {DEV_ADDR, (step_q == S_ADDR_R) ? DIR_READ : DIR_WRITE, 1'b1};
                        end
                    endcase
                end
            end
            M_BYTE: begin
                if (tick) begin
                    quarter_d = quarter_q + 2'd1;
                    case (quarter_q)
                        2'd0: sda_oe_d = !tx_q[8];
                        2'd1: scl_oe_d = 1'b0;
                        2'd2: begin
                        end
                        default: begin
                            scl_oe_d = 1'b1;
                            rx_d = rx_full;
                            bit_d = bit_q + 4'h1;
                            tx_d = {tx_q[7:0], 1'b1};
                            if (bit_q == 4'(BYTE_BITS)) begin
                                bit_d = 4'h0;
                                rx_d = 9'h000;
                                state_d = M_STOP;
                                if (!ack_ok && step_q != S_READ) begin
                                    nack_d = 1'b1;
                                end else begin
                                    case (step_q)
                                        S_ADDR_W: begin
                                            state_d = M_BYTE;
                                            step_d = S_INDEX;
                                            tx_d = {index_q, 1'b1};
                                        end
                                        S_INDEX: begin
                                            if (read_q) begin
                                                state_d = M_START;
                                                step_d = S_ADDR_R;
                                            end else begin
                                                state_d = M_BYTE;
                                                step_d = S_DATA;
                                                tx_d = {data_q, 1'b1};
                                            end
                                        end
                                        S_DATA: begin
                                            if (!last_q) begin
                                                state_d = M_HOLD;
                                                done_d = 1'b1;
                                            end
                                        end
                                        S_ADDR_R: begin
                                            state_d = M_BYTE;
                                            step_d = S_READ;
                                            tx_d = 9'h1ff;
                                        end
                                        default: rd_data_d = rx_full[8:1];
                                    endcase
                                end
                            end
                        end
                    endcase
                end
            end
            M_STOP: begin
                if (tick) begin
                    quarter_d = quarter_q + 2'd1;
                    case (quarter_q)
                        2'd0: sda_oe_d = 1'b1;
                        2'd1: scl_oe_d = 1'b0;
                        2'd2: sda_oe_d = 1'b0;
                        default: begin
                            state_d = M_IDLE;
                            done_d = 1'b1;
                            busy_d = 1'b0;
                        end
                    endcase
                end
            end
            default: state_d = M_IDLE;
        endcase
        ready_d = (state_d == M_IDLE || state_d == M_HOLD);
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= M_IDLE;
            step_q <= S_ADDR_W;
            qcnt_q <= '0;
            quarter_q <= 2'd0;
            bit_q <= 4'h0;
            tx_q <= 9'h1ff;
            rx_q <= 9'h000;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            read_q <= 1'b0;
            last_q <= 1'b1;
            data_q <= 8'h00;
            index_q <= 8'h00;
            cmd_ready_o <= 1'b1;
            done_o <= 1'b0;
            nack_o <= 1'b0;
            rd_data_o <= 8'h00;
            busy_o <= 1'b0;
        end else begin
            state_q <= state_d;
            step_q <= step_d;
            qcnt_q <= qcnt_d;
            quarter_q <= quarter_d;
            bit_q <= bit_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            scl_oe_q <= scl_oe_d;
            sda_oe_q <= sda_oe_d;
            read_q <= read_d;
            last_q <= last_d;
            data_q <= data_d;
            index_q <= index_d;
            cmd_ready_o <= ready_d;
            done_o <= done_d;
            nack_o <= nack_d;
            rd_data_o <= rd_data_d;
            busy_o <= busy_d;
        end
    end
endmodule : i2c_reg_master
`default_nettype wire

// ==== common/i2c_link_pkg.sv ====
package i2c_link_pkg;
    // Fixed bus identity of the register port
    localparam logic [6:0] DEV_ADDR = 7'h60;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    localparam logic ACK_LEVEL = 1'b0;
    localparam int unsigned BYTE_BITS = 8;
    localparam int unsigned NUM_REGS_DEF = 16;

    // Link timing derived from the fastest allowed bit rate
    localparam int unsigned SYS_PERIOD_NS = 8;
    localparam int unsigned MAX_RATE_KBPS = 400;
    localparam int unsigned BIT_NS = 1000000 / MAX_RATE_KBPS;
    localparam int unsigned QUARTER_NS = BIT_NS / 4;
    localparam int unsigned QUARTER_CYC = (QUARTER_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

    typedef enum logic [2:0] {
        SL_IDLE = 3'b000,
        SL_RX = 3'b001,
        SL_ACK = 3'b010,
        SL_TX = 3'b011,
        SL_TX_ACK = 3'b100
    } slave_state_t;

    typedef enum logic [1:0] {
        PH_ADDR = 2'b00,
        PH_INDEX = 2'b01,
        PH_DATA = 2'b10
    } slave_phase_t;

    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_START = 3'b001,
        M_BYTE = 3'b010,
        M_STOP = 3'b011,
        M_HOLD = 3'b100
    } master_state_t;

    typedef enum logic [2:0] {
        S_ADDR_W = 3'b000,
        S_INDEX = 3'b001,
        S_DATA = 3'b010,
        S_ADDR_R = 3'b011,
        S_READ = 3'b100
    } master_step_t;
endpackage : i2c_link_pkg

// ==== common/i2c_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
    logic scl_m_o;
    logic scl_m_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    wire logic scl;
    wire logic sda;

    // Open-drain wires with pull-ups: any enabled low driver wins
    assign scl = (scl_m_oe && !scl_m_o) ? 1'b0 : 1'b1;
    assign sda = ((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o)) ? 1'b0 : 1'b1;

    modport master (output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe, input scl, input sda);
    modport slave (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface : i2c_link_if
`default_nettype wire

// ==== src/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int unsigned WIDTH = 2
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] q_d;

    // Second stage is the only reader of the first
    always_comb begin
        meta_d = d_i;
        q_d = meta_q;
    end

    // Idle bus level is high, so reset to ones avoids a false edge
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_q <= '1;
            q_o <= '1;
        end else begin
            meta_q <= meta_d;
            q_o <= q_d;
        end
    end
endmodule : pin_sync
`default_nettype wire

// ==== src/i2c_reg_slave.sv ====
// What this block does
// - Port timed only by incoming serial clock
// - Works at bit rates up to 400 kbit/s
// - Data changes only while clock is low
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Busy from start until the next stop
// - Repeated start restarts address reception
// - Bytes are eight bits, MSB first
// - Sender releases data during acknowledge pulse
// - Receiver pulls data low on ninth pulse
// - Addressed slave acknowledges every received byte
// - First byte: seven-bit address plus direction
// - Answer only fixed address 60 hex
// - Write: index byte, then data byte
// - Read: write index, repeated start, read
// - Multi-write: address once, index/data pairs
// - Store every index/data pair with an implemented index until stop
`timescale 1ns/1ps
`default_nettype none
module i2c_reg_slave #(
    parameter int unsigned NUM_REGS = i2c_link_pkg::NUM_REGS_DEF
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    i2c_link_if.slave link,
    output logic [NUM_REGS*i2c_link_pkg::BYTE_BITS-1:0] regs_o,
    output logic wr_strobe_o,
    output logic [i2c_link_pkg::BYTE_BITS-1:0] wr_index_o,
    output logic busy_o
);
    import i2c_link_pkg::*;

    localparam int unsigned IW = (NUM_REGS > 1) ? $clog2(NUM_REGS) : 1;

    logic scl_s;
    logic sda_s;
    logic scl_p_q;
    logic sda_p_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    slave_state_t state_q, state_d;
    slave_phase_t phase_q, phase_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] index_q, index_d;
    logic rw_q, rw_d;
    logic mack_q, mack_d;
    logic sda_oe_q, sda_oe_d;
    logic busy_d;
    logic wr_strobe_d;
    logic [7:0] wr_index_d;
    logic [7:0] regs_q [NUM_REGS];
    logic [7:0] regs_d [NUM_REGS];
    logic [7:0] rd_byte;
    logic [7:0] next_idx;

    // Both link wires cross into the system clock domain first
    pin_sync #(
        .WIDTH(2)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .d_i({link.scl, link.sda}),
        .q_o({scl_s, sda_s})
    );

    // Edges of the serial clock drive all bit timing
    assign scl_rise = scl_s && !scl_p_q;
    assign scl_fall = !scl_s && scl_p_q;
    // Data edges while the clock stays high mark start and stop
    assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;

    // Unimplemented indices read as zero and ignore writes
    assign rd_byte = (index_q < NUM_REGS) ? regs_q[index_q[IW-1:0]] : 8'h00;
    assign next_idx = index_q + 8'h01;

    // Open-drain: only ever pull low
    assign link.sda_s_o = 1'b0;
    assign link.sda_s_oe = sda_oe_q;

    // Register bank straight from its flops
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_regs
            assign regs_o[gi*BYTE_BITS +: BYTE_BITS] = regs_q[gi];
        end
    endgenerate

    // Byte engine; receive bit counting follows clock rises, send bit counting and driving follow falls
    always_comb begin
        state_d = state_q;
        phase_d = phase_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        index_d = index_q;
        rw_d = rw_q;
        mack_d = mack_q;
        sda_oe_d = sda_oe_q;
        busy_d = busy_o;
        wr_strobe_d = 1'b0;
        wr_index_d = wr_index_o;
        regs_d = regs_q;
        if (start_det) begin
            // First and repeated start behave the same
            state_d = SL_RX;
            phase_d = PH_ADDR;
            cnt_d = 4'h0;
            sda_oe_d = 1'b0;
            busy_d = 1'b1;
        end else if (stop_det) begin
            state_d = SL_IDLE;
            sda_oe_d = 1'b0;
            busy_d = 1'b0;
        end else begin
            case (state_q)
                SL_IDLE: begin
                    sda_oe_d = 1'b0;
                end
                SL_RX: begin
                    if (scl_rise) begin
                        // Sample while clock is high, MSB arrives first
                        shift_d = {shift_q[6:0], sda_s};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == 4'(BYTE_BITS)) begin
                        cnt_d = 4'h0;
                        case (phase_q)
                            PH_ADDR: begin
                                // Address in upper seven bits, direction last
                                if (shift_q[7:1] == DEV_ADDR) begin
                                    rw_d = shift_q[0];
                                    state_d = SL_ACK;
                                    sda_oe_d = 1'b1;
                                end else begin
                                    // Not ours: stay silent until next start
                                    state_d = SL_IDLE;
                                    sda_oe_d = 1'b0;
                                end
                            end
                            PH_INDEX: begin
                                index_d = shift_q;
                                state_d = SL_ACK;
                                sda_oe_d = 1'b1;
                            end
                            PH_DATA: begin
                                if (index_q < NUM_REGS) begin
                                    regs_d[index_q[IW-1:0]] = shift_q;
                                end
                                wr_strobe_d = 1'b1;
                                wr_index_d = index_q;
                                state_d = SL_ACK;
                                sda_oe_d = 1'b1;
                            end
                            default: begin
                                state_d = SL_IDLE;
                            end
                        endcase
                    end
                end
                SL_ACK: begin
                    // Hold the line low across the whole ninth pulse
                    if (scl_fall) begin
                        sda_oe_d = 1'b0;
                        case (phase_q)
                            PH_ADDR: begin
                                if (rw_q == DIR_READ) begin
                                    // Index came from the preceding write phase
                                    state_d = SL_TX;
                                    shift_d = rd_byte;
                                    sda_oe_d = !rd_byte[7];
                                end else begin
                                    state_d = SL_RX;
                                    phase_d = PH_INDEX;
                                end
                            end
                            PH_INDEX: begin
                                state_d = SL_RX;
                                phase_d = PH_DATA;
                            end
                            default: begin
                                // Another pair may follow until stop
                                state_d = SL_RX;
                                phase_d = PH_INDEX;
                            end
                        endcase
                    end
                end
                SL_TX: begin
                    // New bit only after the clock has fallen
                    if (scl_fall) begin
                        if (cnt_q == 4'(BYTE_BITS - 1)) begin
                            sda_oe_d = 1'b0;
                            state_d = SL_TX_ACK;
                            cnt_d = 4'h0;
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                            sda_oe_d = !shift_q[6];
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                SL_TX_ACK: begin
                    if (scl_rise) begin
                        mack_d = (sda_s == ACK_LEVEL);
                    end else if (scl_fall) begin
                        if (mack_q) begin
                            // Acked: continue with the following register
                            index_d = next_idx;
                            shift_d = (next_idx < NUM_REGS) ? regs_q[next_idx[IW-1:0]] : 8'h00;
                            sda_oe_d = (next_idx < NUM_REGS) ? !regs_q[next_idx[IW-1:0]][7] : 1'b0;
                            state_d = SL_TX;
                        end else begin
                            // Not acked: release and wait for stop
                            sda_oe_d = 1'b0;
                            state_d = SL_IDLE;
                        end
                    end
                end
                default: begin
                    state_d = SL_IDLE;
                    sda_oe_d = 1'b0;
                end
            endcase
        end
    end

    // State registers; bank resets to zero
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            state_q <= SL_IDLE;
            phase_q <= PH_ADDR;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            index_q <= 8'h00;
            rw_q <= DIR_WRITE;
            mack_q <= 1'b0;
            sda_oe_q <= 1'b0;
            busy_o <= 1'b0;
            wr_strobe_o <= 1'b0;
            wr_index_o <= 8'h00;
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= 8'h00;
            end
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            state_q <= state_d;
            phase_q <= phase_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            index_q <= index_d;
            rw_q <= rw_d;
            mack_q <= mack_d;
            sda_oe_q <= sda_oe_d;
            busy_o <= busy_d;
            wr_strobe_o <= wr_strobe_d;
            wr_index_o <= wr_index_d;
            regs_q <= regs_d;
        end
    end
endmodule : i2c_reg_slave
`default_nettype wire

// ==== verif/i2c_link_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module i2c_link_properties #(
    parameter int unsigned QUARTER_CYC = 8
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_m_oe,
    input wire logic sda_s_oe
);
    // Longest clock low phase seen from an acknowledge start
    localparam int LOW_MAX = 4 * QUARTER_CYC;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // Slave moves its data pull only while the clock is low
    property p_s_chg; $changed(sda_s_oe) |-> !scl; endproperty
    a_s_chg: assert property (p_s_chg) else $error("slave data moved with clock high");
    // After a start the address bits belong to the master
    property p_start; $fell(sda) && scl |-> !sda_s_oe [*8]; endproperty
    a_start: assert property (p_start) else $error("slave pulls data after start");
    // After a stop the slave leaves the bus alone
    property p_stop; $rose(sda) && scl |-> !sda_s_oe [*8]; endproperty
    a_stop: assert property (p_stop) else $error("slave pulls data after stop");
    // Only one party drives data while the clock is high; the sender may hold its last bit into the low phase
    property p_clash; scl && sda_s_oe |-> !sda_m_oe; endproperty
    a_clash: assert property (p_clash) else $error("both ends drive data");
    // An acknowledge pull is met by a clock pulse
    property p_ack_pulse; $rose(sda_s_oe) |-> ##[1:LOW_MAX] scl; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("no clock pulse during slave pull");
    // The pull is held, not a glitch
    property p_ack_hold; $rose(sda_s_oe) |-> sda_s_oe [*8]; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("slave pull too short");
    // Clock phases never shorter than eight system clock cycles
    property p_high; $rose(scl) |-> scl [*8]; endproperty
    a_high: assert property (p_high) else $error("clock high phase too short");
    property p_low; $fell(scl) |-> !scl [*8]; endproperty
    a_low: assert property (p_low) else $error("clock low phase too short");
endmodule : i2c_link_properties
`default_nettype wire

// ==== verif/tb_i2c_register_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_register_slave;
    import i2c_link_pkg::*;
    localparam int unsigned QC = 8;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic cmd_valid_i = 1'b0;
    logic cmd_read_i = 1'b0;
    logic cmd_last_i = 1'b1;
    logic [7:0] cmd_index_i = 8'h00;
    logic [7:0] cmd_data_i = 8'h00;
    logic cmd_ready_o, done_o, nack_o, busy_o, wr_strobe_o, saw_busy, m_busy;
    logic [7:0] rd_data_o, wr_index_o;
    logic [NUM_REGS_DEF*8-1:0] regs_o;
    int fail_count = 0;
    int total_checks = 0;
    int strobes = 0;
    int s0;
    i2c_link_if link_bus();
    i2c_reg_master #(.QUARTER_CYC(QC)) i_i2c_reg_master (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .link(link_bus), .cmd_valid_i(cmd_valid_i), .cmd_read_i(cmd_read_i), .cmd_last_i(cmd_last_i),
        .cmd_index_i(cmd_index_i), .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o),
        .nack_o(nack_o), .rd_data_o(rd_data_o), .busy_o(m_busy));
    i2c_reg_slave i_i2c_reg_slave (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .link(link_bus), .regs_o(regs_o),
        .wr_strobe_o(wr_strobe_o), .wr_index_o(wr_index_o), .busy_o(busy_o));
    i2c_link_properties #(.QUARTER_CYC(QC)) i_props (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .scl(link_bus.scl), .sda(link_bus.sda), .sda_m_oe(link_bus.sda_m_oe), .sda_s_oe(link_bus.sda_s_oe));
    initial begin
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    // Count received data bytes, stored or not
    always @(posedge sys_clk_i) if (wr_strobe_o === 1'b1) strobes <= strobes + 1;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Held request until taken, then bounded wait for done
    task automatic cmd(input logic rd, input logic lst, input logic [7:0] ix, input logic [7:0] dt);
        int n;
        n = 0;
        saw_busy = 1'b0;
        cmd_valid_i = 1'b1;
        cmd_read_i = rd;
        cmd_last_i = lst;
        cmd_index_i = ix;
        cmd_data_i = dt;
        do @(posedge sys_clk_i); while (cmd_ready_o !== 1'b1);
        #1 cmd_valid_i = 1'b0;
        do begin
            @(posedge sys_clk_i);
            #1;
            n++;
            saw_busy |= (busy_o === 1'b1);
        end while (done_o !== 1'b1 && n < 5000);
        chk({7'h00, n < 5000}, 8'h01);
    endtask : cmd
    task automatic t_write;
        cmd(1'b0, 1'b1, 8'h03, 8'ha5);
        chk(regs_o[3*8+:8], 8'ha5);
        chk(wr_index_o, 8'h03);
        chk({7'h00, nack_o}, 8'h00);
        chk({7'h00, m_busy}, 8'h00);
        chk({7'h00, saw_busy}, 8'h01);
        repeat (4) @(posedge sys_clk_i);
        #1 chk({7'h00, busy_o}, 8'h00);
        $display("t_write done");
    endtask : t_write
    task automatic t_multi;
        s0 = strobes;
        cmd(1'b0, 1'b0, 8'h05, 8'h3c);
        chk({7'h00, busy_o}, 8'h01);
        chk({7'h00, m_busy}, 8'h01);
        cmd(1'b0, 1'b1, 8'h0f, 8'h81);
        chk(regs_o[5*8+:8], 8'h3c);
        chk(regs_o[15*8+:8], 8'h81);
        chk(8'(strobes - s0), 8'h02);
        chk({7'h00, nack_o}, 8'h00);
        $display("t_multi done");
    endtask : t_multi
    task automatic t_read;
        cmd(1'b1, 1'b1, 8'h05, 8'h00);
        chk(rd_data_o, 8'h3c);
        chk({7'h00, nack_o}, 8'h00);
        cmd(1'b1, 1'b1, 8'h03, 8'h00);
        chk(rd_data_o, 8'ha5);
        $display("t_read done");
    endtask : t_read
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up
    // Reset for four cycles, then the scenarios
    initial begin
        repeat (4) @(posedge sys_clk_i);
        #1 reset_i = 1'b0;
        t_write();
        t_multi();
        t_read();
        wrap_up();
    end
    // Cuts a hang; the tests need about 40 us
    initial begin
        #200000;
        fail_count++;
        wrap_up();
    end
endmodule : tb_i2c_register_slave
`default_nettype wire
